// ===== include/rtd_defines.svh
// Register map, unlock keys and reset values of the tamper detector
// What this block does
// - Per-input level bit selects active pin level
// - Detection only on inputs whose enable is set
// - Interrupt only while common interrupt enable set
// - Precharge-off clear: weak pull-up before each sample
// - Pull-up lasts 1, 2, 4 or 8 cycles
// - Precharge length ignored when precharge is off
// - Event after 1, 2, 4 or 8 active samples
// - Sample rate is kernel clock / (32768 >> code)
// - Control registers cleared by power-on reset only
// - Control writes need the unlock key sequence
`ifndef RTD_DEFINES_SVH
`define RTD_DEFINES_SVH

// Register indices; byte address is four times the index
`define RTD_IDX_TCR1   8'h2C
`define RTD_IDX_TCR2   8'h2D
`define RTD_IDX_STAT   8'h2E
`define RTD_IDX_MASK   8'h2F
`define RTD_IDX_KEY    8'h30

`define RTD_TCR_RESET  8'h00
`define RTD_TCR1_WMASK 8'h7F
`define RTD_FLAG_W     3
`define RTD_FLAG_RESET 3'h0

// Unlock keys, values arbitrary
`define RTD_KEY_FIRST  8'hA5
`define RTD_KEY_SECOND 8'h5A

// Slowest sampling divider
`define RTD_DIV_MAX    16'h8000
`define RTD_CNT_RESET  16'h0000
`define RTD_FCNT_RESET 4'h0

`endif

// ===== include/rtd_pkg.sv
// Types shared by the tamper detector
package rtd_pkg;

  typedef struct packed {
    logic rsvd;
    logic input3_active_level;
    logic input3_detect_enable;
    logic input2_active_level;
    logic input2_detect_enable;
    logic input1_active_level;
    logic input1_detect_enable;
    logic intrusion_irq_enable;
  } rtd_tcr1_t;

  typedef struct packed {
    logic       precharge_off;
    logic [1:0] precharge_length;
    logic [1:0] sample_filter_count;
    logic [2:0] sample_rate_select;
  } rtd_tcr2_t;

  typedef enum logic [1:0] {
    RTD_LOCKED,
    RTD_KEY1_SEEN,
    RTD_UNLOCKED
  } rtd_lock_t;

endpackage

// ===== logic/rtd_tamper.sv
// Tamper detector with APB register access
//
// The APB slave port is this design's own decision.
`include "rtd_defines.svh"

module rtd_tamper (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        por_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [2:0]  intrusion_pin_i,
  output logic      [2:0]  pullup_en_o,
  output logic             irq_o
);

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [15:0] period(input logic [2:0] s);
    period = `RTD_DIV_MAX >> s;
  endfunction

  function automatic logic [3:0] pow2(input logic [1:0] c);
    pow2 = 4'h1 << c;
  endfunction

  rtd_pkg::rtd_tcr1_t tcr1_q, tcr1_d;
  rtd_pkg::rtd_tcr2_t tcr2_q, tcr2_d;
  rtd_pkg::rtd_lock_t lock_q, lock_d;
  logic [2:0]  flag_q, flag_d, mask_q, mask_d, evt;
  logic [2:0]  en, lvl;
  logic [15:0] cnt_q, cnt_d, per;
  logic [3:0]  fcnt_q [3];
  logic [3:0]  fcnt_d [3];
  logic [3:0]  need, plen;
  logic        tick, sys_rst;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pull_win;
  logic [2:0]  pull_q, pull_d;
  logic        irq_q, irq_d;
  logic [3:0]  pull_run_q, pull_run_d;
  logic        wr, wr_tcr1, wr_tcr2, wr_stat, wr_mask, wr_key, mapped;

  assign sys_rst = reset_i || por_i;
  assign en  = {tcr1_q.input3_detect_enable, tcr1_q.input2_detect_enable,
                tcr1_q.input1_detect_enable};
  assign lvl = {tcr1_q.input3_active_level, tcr1_q.input2_active_level,
                tcr1_q.input1_active_level};

  // Bus decode: answer comes one cycle into the access phase
  always_comb
  begin
    mapped  = hit(paddr_i, `RTD_IDX_TCR1) || hit(paddr_i, `RTD_IDX_TCR2) ||
              hit(paddr_i, `RTD_IDX_STAT) || hit(paddr_i, `RTD_IDX_MASK) ||
              hit(paddr_i, `RTD_IDX_KEY);
    // A transfer that ends on a reset edge must not touch the control regs
    wr      = psel_i && penable_i && pready_q && pwrite_i && !sys_rst;
    wr_tcr1 = wr && hit(paddr_i, `RTD_IDX_TCR1);
    wr_tcr2 = wr && hit(paddr_i, `RTD_IDX_TCR2);
    wr_stat = wr && hit(paddr_i, `RTD_IDX_STAT);
    wr_mask = wr && hit(paddr_i, `RTD_IDX_MASK);
    wr_key  = wr && hit(paddr_i, `RTD_IDX_KEY);
    pready_d  = psel_i && penable_i && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d  = 32'h0000_0000;
    if (pready_d && !pwrite_i)
    begin
      if (hit(paddr_i, `RTD_IDX_TCR1))
        prdata_d[7:0] = tcr1_q;
      else if (hit(paddr_i, `RTD_IDX_TCR2))
        prdata_d[7:0] = tcr2_q;
      else if (hit(paddr_i, `RTD_IDX_STAT))
        prdata_d[2:0] = flag_q;
      else if (hit(paddr_i, `RTD_IDX_MASK))
        prdata_d[2:0] = mask_q;
      else if (hit(paddr_i, `RTD_IDX_KEY))
        prdata_d[0] = (lock_q == rtd_pkg::RTD_UNLOCKED);
    end
  end

  // Unlock sequence; any wrong key write locks again
  always_comb
  begin
    lock_d = lock_q;
    if (wr_key)
    begin
      case (lock_q)
        rtd_pkg::RTD_LOCKED:
          lock_d = (pwdata_i[7:0] == `RTD_KEY_FIRST) ?
                   rtd_pkg::RTD_KEY1_SEEN : rtd_pkg::RTD_LOCKED;
        rtd_pkg::RTD_KEY1_SEEN:
          lock_d = (pwdata_i[7:0] == `RTD_KEY_SECOND) ?
                   rtd_pkg::RTD_UNLOCKED : rtd_pkg::RTD_LOCKED;
        rtd_pkg::RTD_UNLOCKED:
          lock_d = rtd_pkg::RTD_LOCKED;
        default:
          lock_d = rtd_pkg::RTD_LOCKED;
      endcase
    end
  end

  // Control registers, guarded by the unlock state
  always_comb
  begin
    tcr1_d = tcr1_q;
    tcr2_d = tcr2_q;
    if (wr_tcr1 && lock_q == rtd_pkg::RTD_UNLOCKED)
      tcr1_d = pwdata_i[7:0] & `RTD_TCR1_WMASK;
    if (wr_tcr2 && lock_q == rtd_pkg::RTD_UNLOCKED)
      tcr2_d = pwdata_i[7:0];
  end

  // Sampling divider and precharge window
  always_comb
  begin
    per  = period(tcr2_q.sample_rate_select);
    tick = cnt_q >= per - 16'h0001;
    cnt_d = tick ? `RTD_CNT_RESET : cnt_q + 16'h0001;
    plen = pow2(tcr2_q.precharge_length);
    // Pull-up covers the last plen counts before the sample
    pull_win = cnt_d >= per - {12'h000, plen};
    pull_d = (tcr2_q.precharge_off ? 3'h0 : {3{pull_win}}) & en;
    // Length of the running pull-up pulse on pin one, read by checks only
    if (!pull_q[0])
      pull_run_d = 4'h0;
    else if (pull_run_q != 4'hF)
      pull_run_d = pull_run_q + 4'h1;
    else
      pull_run_d = pull_run_q;
  end

  // Consecutive-sample filter per input
  always_comb
  begin
    need = pow2(tcr2_q.sample_filter_count);
    evt  = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      fcnt_d[i] = fcnt_q[i];
      if (!en[i])
        fcnt_d[i] = `RTD_FCNT_RESET;
      else if (tick)
      begin
        if (intrusion_pin_i[i] != lvl[i])
          fcnt_d[i] = `RTD_FCNT_RESET;
        else if (fcnt_q[i] < need)
        begin
          fcnt_d[i] = fcnt_q[i] + 4'h1;
          evt[i]    = (fcnt_q[i] + 4'h1) == need;
        end
        else
          fcnt_d[i] = need;
      end
    end
  end

  // Sticky flags: a new event wins over a same-cycle clear
  always_comb
  begin
    flag_d = flag_q;
    mask_d = mask_q;
    if (wr_stat)
      flag_d = flag_q & ~pwdata_i[2:0];
    flag_d = flag_d | evt;
    if (wr_mask)
      mask_d = pwdata_i[2:0];
    irq_d = tcr1_q.intrusion_irq_enable && |(flag_d & mask_d);
  end

  // Control registers survive a system reset
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      tcr1_q <= `RTD_TCR_RESET;
      tcr2_q <= `RTD_TCR_RESET;
    end
    else
    begin
      tcr1_q <= tcr1_d;
      tcr2_q <= tcr2_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst)
    begin
      lock_q    <= rtd_pkg::RTD_LOCKED;
      flag_q    <= `RTD_FLAG_RESET;
      mask_q    <= `RTD_FLAG_RESET;
      cnt_q     <= `RTD_CNT_RESET;
      pull_q    <= 3'h0;
      irq_q     <= 1'b0;
      pull_run_q <= 4'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      for (int i = 0; i < 3; i++)
        fcnt_q[i] <= `RTD_FCNT_RESET;
    end
    else
    begin
      lock_q    <= lock_d;
      flag_q    <= flag_d;
      mask_q    <= mask_d;
      cnt_q     <= cnt_d;
      pull_q    <= pull_d;
      irq_q     <= irq_d;
      pull_run_q <= pull_run_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      for (int i = 0; i < 3; i++)
        fcnt_q[i] <= fcnt_d[i];
    end
  end

  assign prdata_o    = prdata_q;
  assign pready_o    = pready_q;
  assign pslverr_o   = pslverr_q;
  assign pullup_en_o = pull_q;
  assign irq_o       = irq_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst);

  sequence s_long_pull;
    $rose(pull_q[0]) && tcr2_q.precharge_length == 2'h3;
  endsequence

  sequence s_pull_steady;
    ($stable(tcr2_q) && $stable(en)) [*8];
  endsequence

  a_level_select: assert property (
    $rose(flag_q[0]) |-> $past(intrusion_pin_i[0] == lvl[0]))
    else $error("flag set on an inactive pin level");

  a_enable_gate: assert property (
    $rose(flag_q[1]) |-> $past(en[1]))
    else $error("flag set on a disabled input");

  a_irq_gate: assert property (
    !$past(tcr1_q.intrusion_irq_enable) |-> !irq_o)
    else $error("interrupt while interrupt enable is clear");

  a_irq_follow: assert property (
    irq_o == ($past(tcr1_q.intrusion_irq_enable) && |(flag_q & mask_q)))
    else $error("interrupt does not follow unmasked flags");

  a_pull_off: assert property (
    $past(tcr2_q.precharge_off) |-> pull_q == 3'h0)
    else $error("pull-up active with precharge off");

  a_pull_gate: assert property (
    (pull_q & ~$past(en)) == 3'h0)
    else $error("pull-up on a disabled input");

  a_pull_length: assert property (
    s_long_pull ##0 s_pull_steady |=> !pull_q[0] && pull_run_q == 4'h8)
    else $error("pull-up not held eight cycles");

  a_filter_count: assert property (
    $rose(flag_q[0]) |-> fcnt_q[0] == $past(need))
    else $error("event before filter count reached");

  a_rate_slow: assert property (
    tick && tcr2_q.sample_rate_select == 3'h7 |->
      ##256 (tick || tcr2_q.sample_rate_select != 3'h7))
    else $error("sample period not 256 cycles");

  a_por_clear: assert property (
    @(posedge clk_i) disable iff (1'b0)
    por_i |=> tcr1_q == 8'h00 && tcr2_q == 8'h00)
    else $error("control registers not cleared at power-on");

  a_reset_keep: assert property (
    @(posedge clk_i) disable iff (1'b0)
    reset_i && !por_i |=> $stable(tcr1_q) && $stable(tcr2_q))
    else $error("system reset changed a control register");

  a_locked_write: assert property (
    wr_tcr2 && lock_q != rtd_pkg::RTD_UNLOCKED |=> $stable(tcr2_q))
    else $error("control write accepted while locked");

  a_locked_first: assert property (
    wr_tcr1 && lock_q != rtd_pkg::RTD_UNLOCKED |=> $stable(tcr1_q))
    else $error("first control write accepted while locked");

  a_reserved_bit: assert property (
    !tcr1_q.rsvd)
    else $error("reserved control bit set");

  a_flag_sticky: assert property (
    flag_q[2] && !(wr_stat && pwdata_i[2]) |=> flag_q[2])
    else $error("flag dropped without a clear");

  a_filter_restart: assert property (
    tick && en[0] && intrusion_pin_i[0] != lvl[0] |=> fcnt_q[0] == 4'h0)
    else $error("filter count kept after an inactive sample");

endmodule

// ===== tb/rtd_switch_model.sv
// Model of the tamper switches on the three intrusion pins
module rtd_switch_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] short_lo_i,
  input  wire logic [2:0] short_hi_i,
  input  wire logic [2:0] pullup_en_i,
  output logic      [2:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] float_q = 3'h0;
  always_ff @(posedge clk_i)
  begin
    float_q <= ~float_q;
  end
  // An open pin with no pull-up floats, so it toggles rather than hold
  assign pin_o = short_hi_i | (~short_lo_i & (pullup_en_i | float_q));
endmodule

// ===== tb/rtd_tamper_tb.sv
// Self-checking bench of the tamper detector
`include "rtd_defines.svh"
module rtd_tamper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] AD_TCR1 = {2'h0, `RTD_IDX_TCR1, 2'h0};
  localparam logic [11:0] AD_TCR2 = {2'h0, `RTD_IDX_TCR2, 2'h0};
  localparam logic [11:0] AD_STAT = {2'h0, `RTD_IDX_STAT, 2'h0};
  localparam logic [11:0] AD_MASK = {2'h0, `RTD_IDX_MASK, 2'h0};
  localparam logic [11:0] AD_KEY  = {2'h0, `RTD_IDX_KEY, 2'h0};
  logic        clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, irq_o, err, prev;
  logic [2:0]  pin, pullup_en_o, lo = 3'h7, hi = 3'h0;
  int          n_mismatch = 0, checked = 0, cnt;

  always #25 clk_i = ~clk_i;

  rtd_tamper DUT (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .intrusion_pin_i(pin),
    .pullup_en_o(pullup_en_o), .irq_o(irq_o));
  rtd_switch_model SW (.clk_i(clk_i), .short_lo_i(lo), .short_hi_i(hi),
    .pullup_en_i(pullup_en_o), .pin_o(pin));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // Wait until pready_o is high; the watchdog ends a wait that never sees it
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so the next setup never re-drives psel in this step
    @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #3000000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    cyc(4);
    reset_i <= 1'b0;
    por_i   <= 1'b0;
    cyc(1);
    rdchk(AD_TCR1, 32'h0, "tcr1 por");
    rdchk(AD_TCR2, 32'h0, "tcr2 por");
    apb(1'b1, AD_TCR1, 32'hFF);
    rdchk(AD_TCR1, 32'h0, "tcr1 locked");
    apb(1'b1, 12'h004, 32'h0);
    chk("unmapped err", 32'h1, err);
    apb(1'b1, AD_KEY, `RTD_KEY_FIRST);
    apb(1'b1, AD_KEY, `RTD_KEY_SECOND);
    apb(1'b1, AD_TCR1, 32'hFF);
    rdchk(AD_TCR1, 32'h7F, "tcr1 bit7");
    apb(1'b1, AD_TCR1, 32'h02);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, AD_TCR2, (k == 4) ? 32'hE7 : {k[1:0], 5'h07});
      cyc(256);
      cnt = 0;
      repeat (512)
      begin
        @(posedge clk_i);
        cnt += (pullup_en_o === 3'h1);
      end
      chk("pullup cycles", (k == 4) ? 0 : 2 << k, cnt);
    end
    apb(1'b1, AD_TCR2, 32'h67);
    apb(1'b1, AD_MASK, 32'h7);
    for (int i = 0; i < 6; i++)
    begin
      lo <= ~(3'h1 << (i / 2));
      apb(1'b1, AD_TCR1, (32'h2 | (i % 2) << 2) << (i / 2 * 2) | 32'h1);
      apb(1'b1, AD_STAT, 32'h7);
      cyc(600);
      rdchk(AD_STAT, (i % 2) << (i / 2), "stat level");
      chk("irq", i % 2, irq_o);
    end
    apb(1'b1, AD_MASK, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, irq_o);
    apb(1'b1, AD_MASK, 32'h7);
    apb(1'b1, AD_TCR1, 32'h20);
    cyc(2);
    chk("irq disabled", 32'h0, irq_o);
    lo <= 3'h7;
    hi <= 3'h1;
    apb(1'b1, AD_TCR1, 32'h03);
    apb(1'b1, AD_TCR2, 32'h77);
    apb(1'b1, AD_STAT, 32'h7);
    cyc(300);
    hi <= 3'h0;
    cyc(700);
    hi <= 3'h1;
    cyc(300);
    rdchk(AD_STAT, 32'h0, "stat short run");
    hi <= 3'h0;
    cyc(1100);
    rdchk(AD_STAT, 32'h1, "stat long run");
    hi <= 3'h1;
    cyc(600);
    rdchk(AD_STAT, 32'h1, "stat sticky");
    apb(1'b1, AD_STAT, 32'h1);
    rdchk(AD_STAT, 32'h0, "stat clear");
    hi <= 3'h0;
    apb(1'b1, AD_TCR1, 32'h02);
    // Divider grows each step so the running count never overshoots
    for (int r = 7; r > 4; r--)
    begin
      apb(1'b1, AD_TCR2, r);
      cyc(1100);
      cnt  = 0;
      prev = pullup_en_o[0];
      repeat (4096)
      begin
        @(posedge clk_i);
        cnt += (pullup_en_o[0] === 1'b1 && prev === 1'b0);
        prev = pullup_en_o[0];
      end
      chk("sample ticks", 1 << (r - 3), cnt);
    end
    reset_i <= 1'b1;
    cyc(2);
    reset_i <= 1'b0;
    cyc(1);
    rdchk(AD_TCR1, 32'h02, "tcr1 sysreset");
    rdchk(AD_TCR2, 32'h05, "tcr2 sysreset");
    apb(1'b1, AD_TCR1, 32'h0);
    rdchk(AD_TCR1, 32'h02, "tcr1 relocked");
    por_i <= 1'b1;
    cyc(2);
    por_i <= 1'b0;
    cyc(1);
    rdchk(AD_TCR1, 32'h0, "tcr1 por again");
    print_verdict();
  end
endmodule
